// *** rtl/spsd_top.sv ***
// spsd_top.sv: status and data registers with 4-deep fifos of a serial
// master. assumes an avalon-mm master on SYS_CLK and a link clock pin.
//
// Local design decision: the Avalon-MM slave port.
`timescale 1ns/1ps
`include "spsd_defs.svh"
module spsd_top
#(
    parameter int DEPTH = 4
)
(
    input  wire logic        SYS_CLK,
    input  wire logic        SRST,
    input  wire logic [15:0] AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic [31:0]      AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic [1:0]       AVS_RESPONSE,
    input  wire logic        LINK_SCK,
    input  wire logic        LINK_MISO,
    output logic             LINK_MOSI,
    output logic             IRQ
);
    import spsd_pkg::*;

    typedef struct packed {
        logic [DEPTH-1:0][15:0] txm;
        logic [DEPTH-1:0][15:0] rxm;
        logic [1:0]             tx_rd;
        logic [1:0]             rx_rd;
        logic [2:0]             tx_cnt;
        logic [2:0]             rx_cnt;
        logic                   ovr;
        logic                   cfg;
        logic                   stop;
        logic [4:0]             size;
        logic [9:0]             gap;
        logic [9:0]             gap_cnt;
        spsd_state_t            st;
        logic                   start;
        logic [15:0]            tx_word;
        logic [2:0]             irq_st;
        logic [2:0]             irq_mask;
        logic                   ack;
        logic [31:0]            rdata;
        logic [1:0]             resp;
        logic                   txirq_prev;
        logic                   rxirq_prev;
    } spsd_reg_t;

    spsd_reg_t q;
    spsd_reg_t d;
    logic        sh_busy;
    logic        sh_done;
    logic [15:0] sh_rx;

    function automatic logic [1:0] slot(input logic [1:0] base,
                                        input logic [2:0] cnt);
        slot = base + cnt[1:0];
    endfunction

    function automatic logic mapped(input logic [15:0] a);
        mapped = (a == `SPSD_OFF_CTRL) || (a == `SPSD_OFF_SIZE) ||
                 (a == `SPSD_OFF_GAP) || (a == `SPSD_OFF_STATUS) ||
                 (a == `SPSD_OFF_DATA) || (a == `SPSD_OFF_IRQ_ST) ||
                 (a == `SPSD_OFF_IRQ_MASK);
    endfunction

    function automatic logic [15:0] fit(input logic [15:0] w,
                                        input logic [4:0] sz);
        fit = (sz == `SPSD_SIZE_16) ? w : {8'h00, w[7:0]};
    endfunction

    logic        tx_irq;
    logic        rx_irq;
    logic        idle;
    logic [15:0] status;
    logic        req;
    logic        acc;
    logic        wr_data;
    logic        rd_data;
    logic        push_tx;
    logic        pop_tx;
    logic        push_rx;
    logic        pop_rx;
    logic [2:0]  ev;

    always_comb
    begin
        // fewer than half the tx slots used counts as room to refill
        tx_irq = q.tx_cnt < `SPSD_TX_IRQ_LVL;
        rx_irq = q.rx_cnt != 3'h0;
        idle = (q.st == ST_IDLE) && (q.tx_cnt == 3'h0 || q.stop);
        status = 16'h0000;
        status[`SPSD_BIT_TXIRQ] = tx_irq;
        status[`SPSD_BIT_RXIRQ] = rx_irq;
        status[13:11] = q.tx_cnt;
        status[10:8] = q.rx_cnt;
        status[`SPSD_BIT_OVR] = q.ovr;
        status[`SPSD_BIT_GAP] = (q.st == ST_GAP);
        status[`SPSD_BIT_IDLE] = idle;
        status[`SPSD_BIT_TXSP] = q.tx_cnt != `SPSD_FIFO_FULL;
        status[`SPSD_BIT_RXDAT] = q.rx_cnt != 3'h0;

        d = q;
        d.start = 1'b0;
        d.ack = 1'b0;
        d.txirq_prev = tx_irq;
        d.rxirq_prev = rx_irq;
        req = (AVS_READ | AVS_WRITE) & ~q.ack;
        // side effects only on the edge that completes the transfer
        acc = (AVS_READ | AVS_WRITE) & q.ack;
        wr_data = acc & AVS_WRITE & (AVS_ADDRESS == `SPSD_OFF_DATA);
        rd_data = acc & AVS_READ & (AVS_ADDRESS == `SPSD_OFF_DATA);
        push_tx = wr_data && q.tx_cnt != `SPSD_FIFO_FULL;
        pop_tx = 1'b0;
        push_rx = sh_done && q.rx_cnt != `SPSD_FIFO_FULL;
        pop_rx = rd_data && q.rx_cnt != 3'h0;
        ev = 3'h0;

        if (push_tx)
            d.txm[slot(q.tx_rd, q.tx_cnt)] = AVS_WRITEDATA[15:0];
        if (push_rx)
            d.rxm[slot(q.rx_rd, q.rx_cnt)] = fit(sh_rx, q.size);
        if (wr_data && q.tx_cnt == `SPSD_FIFO_FULL)
            ev[`SPSD_IRQ_OVR] = 1'b1;

        unique case (q.st)
            ST_IDLE:
            begin
                // shifter empty: hand it the next word
                if (q.tx_cnt != 3'h0 && !q.stop && !q.cfg && !sh_busy)
                begin
                    pop_tx = 1'b1;
                    d.tx_word = q.txm[q.tx_rd];
                    d.start = 1'b1;
                    d.st = ST_SHIFT;
                end
            end
            ST_SHIFT:
            begin
                if (sh_done)
                begin
                    d.gap_cnt = q.gap;
                    d.st = (q.gap != 10'h000) ? ST_GAP : ST_IDLE;
                end
            end
            ST_GAP:
            begin
                d.gap_cnt = q.gap_cnt - 10'h001;
                if (q.gap_cnt == 10'h001)
                    d.st = ST_IDLE;
            end
        endcase

        if (pop_tx)
            d.tx_rd = q.tx_rd + 2'h1;
        if (pop_rx)
            d.rx_rd = q.rx_rd + 2'h1;
        d.tx_cnt = q.tx_cnt + {2'b00, push_tx} - {2'b00, pop_tx};
        d.rx_cnt = q.rx_cnt + {2'b00, push_rx} - {2'b00, pop_rx};

        ev[`SPSD_IRQ_TXIRQ] = tx_irq & ~q.txirq_prev;
        ev[`SPSD_IRQ_RXIRQ] = rx_irq & ~q.rxirq_prev;

        if (req)
        begin
            d.ack = 1'b1;
            d.rdata = 32'h0000_0000;
            d.resp = mapped(AVS_ADDRESS) ? 2'b00 : 2'b11;
            if (AVS_READ)
            begin
                unique case (AVS_ADDRESS)
                    `SPSD_OFF_CTRL:
                        d.rdata = {30'h0, q.stop, q.cfg};
                    `SPSD_OFF_SIZE:
                        d.rdata = {27'h0, q.size};
                    `SPSD_OFF_GAP:
                        d.rdata = {22'h0, q.gap};
                    `SPSD_OFF_STATUS:
                        d.rdata = {16'h0, status};
                    `SPSD_OFF_DATA:
                        // empty fifo reads as zero
                        d.rdata = (q.rx_cnt != 3'h0) ?
                            {16'h0, q.rxm[q.rx_rd]} : 32'h0;
                    `SPSD_OFF_IRQ_ST:
                        d.rdata = {29'h0, q.irq_st};
                    `SPSD_OFF_IRQ_MASK:
                        d.rdata = {29'h0, q.irq_mask};
                    default:
                        d.rdata = 32'h0000_0000;
                endcase
            end
        end

        if (acc && AVS_WRITE)
        begin
            begin
                unique case (AVS_ADDRESS)
                    `SPSD_OFF_CTRL:
                    begin
                        if (AVS_BYTEENABLE[0])
                        begin
                            d.cfg = AVS_WRITEDATA[`SPSD_CTRL_CFG];
                            d.stop = AVS_WRITEDATA[`SPSD_CTRL_STOP];
                        end
                    end
                    `SPSD_OFF_SIZE:
                        if (q.cfg && AVS_BYTEENABLE[0])
                            d.size = AVS_WRITEDATA[4:0];
                    `SPSD_OFF_GAP:
                    begin
                        if (AVS_BYTEENABLE[0])
                            d.gap[7:0] = AVS_WRITEDATA[7:0];
                        if (AVS_BYTEENABLE[1])
                            d.gap[9:8] = AVS_WRITEDATA[9:8];
                    end
                    `SPSD_OFF_STATUS:
                        if (AVS_BYTEENABLE[0] && AVS_WRITEDATA[`SPSD_BIT_OVR])
                            d.ovr = 1'b0;
                    `SPSD_OFF_DATA: ;
                    `SPSD_OFF_IRQ_ST:
                        d.irq_st = q.irq_st & ~AVS_WRITEDATA[2:0];
                    `SPSD_OFF_IRQ_MASK:
                        d.irq_mask = AVS_WRITEDATA[2:0];
                    default: ;
                endcase
            end
        end

        // events win over software clears
        d.irq_st = d.irq_st | ev;
        if (ev[`SPSD_IRQ_OVR])
            d.ovr = 1'b1;
        else if (q.cfg)
            d.ovr = 1'b0;
    end

    always_ff @(posedge SYS_CLK)
    begin
        if (SRST)
        begin
            q <= '0;
            q.txirq_prev <= 1'b1;
        end
        else
            q <= d;
    end

    spsd_shift u_shift
    (
        .clk     (SYS_CLK),
        .srst    (SRST),
        .sck_in  (LINK_SCK),
        .miso_in (LINK_MISO),
        .start   (q.start),
        .tx_word (q.tx_word),
        .wide    (q.size == `SPSD_SIZE_16),
        .mosi    (LINK_MOSI),
        .busy    (sh_busy),
        .done    (sh_done),
        .rx_word (sh_rx)
    );

    assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~q.ack;
    assign AVS_READDATA = q.rdata;
    assign AVS_RESPONSE = q.resp;
    assign IRQ = |(q.irq_st & q.irq_mask);
endmodule // spsd_top

// *** include/spsd_defs.svh ***
// spsd_defs.svh: offsets, field positions, sizes and fifo levels for the
// serial status/data block. assumes a 32-bit avalon-mm byte-addressed map.
`ifndef SPSD_DEFS_SVH
`define SPSD_DEFS_SVH
`define SPSD_OFF_CTRL     16'hF800
`define SPSD_OFF_SIZE     16'hF808
`define SPSD_OFF_GAP      16'hF80C
`define SPSD_OFF_STATUS   16'hF814
`define SPSD_OFF_DATA     16'hF818
`define SPSD_OFF_IRQ_ST   16'hF820
`define SPSD_OFF_IRQ_MASK 16'hF824
`define SPSD_BIT_TXIRQ    15
`define SPSD_BIT_RXIRQ    14
`define SPSD_BIT_OVR      7
`define SPSD_BIT_GAP      3
`define SPSD_BIT_IDLE     2
`define SPSD_BIT_TXSP     1
`define SPSD_BIT_RXDAT    0
`define SPSD_CTRL_CFG     0
`define SPSD_CTRL_STOP    1
`define SPSD_SIZE_8       5'h08
`define SPSD_SIZE_16      5'h10
`define SPSD_FIFO_FULL    3'h4
`define SPSD_TX_IRQ_LVL   3'h2
`define SPSD_IRQ_OVR      0
`define SPSD_IRQ_TXIRQ    1
`define SPSD_IRQ_RXIRQ    2
`endif

// *** include/spsd_pkg.sv ***
// spsd_pkg.sv: types shared by the serial status/data block.
// assumes spsd_defs.svh for numeric constants.
package spsd_pkg;
    typedef enum logic [1:0] {ST_IDLE, ST_SHIFT, ST_GAP} spsd_state_t;
endpackage

// *** rtl/spsd_shift.sv ***
// spsd_shift.sv: serial shifter, samples the external link clock.
// assumes link clock and miso are asynchronous pins; msb first, mode 0.
`timescale 1ns/1ps
module spsd_shift
(
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        sck_in,
    input  wire logic        miso_in,
    input  wire logic        start,
    input  wire logic [15:0] tx_word,
    input  wire logic        wide,
    output logic             mosi,
    output logic             busy,
    output logic             done,
    output logic [15:0]      rx_word
);
    typedef struct packed {
        logic [1:0]  sck_s;
        logic [1:0]  miso_s;
        logic        sck_prev;
        logic [15:0] sh;
        logic [15:0] rx;
        logic [4:0]  cnt;
        logic        busy;
        logic        done;
    } spsd_sh_t;
    spsd_sh_t q;
    spsd_sh_t d;
    logic rise;
    logic fall;
    always_comb
    begin
        d = q;
        d.sck_s = {q.sck_s[0], sck_in};
        d.miso_s = {q.miso_s[0], miso_in};
        d.sck_prev = q.sck_s[1];
        d.done = 1'b0;
        rise = q.sck_s[1] & ~q.sck_prev;
        fall = ~q.sck_s[1] & q.sck_prev;
        if (start && !q.busy)
        begin
            d.busy = 1'b1;
            d.sh = wide ? tx_word : {tx_word[7:0], 8'h00};
            d.cnt = wide ? 5'h10 : 5'h08;
            d.rx = 16'h0000;
        end
        else if (q.busy && rise)
        begin
            d.rx = {q.rx[14:0], q.miso_s[1]};
            d.cnt = q.cnt - 5'h01;
        end
        else if (q.busy && fall)
        begin
            d.sh = {q.sh[14:0], 1'b0};
            if (q.cnt == 5'h00)
            begin
                d.busy = 1'b0;
                d.done = 1'b1;
            end
        end
    end
    always_ff @(posedge clk)
    begin
        if (srst)
            q <= '0;
        else
            q <= d;
    end
    assign mosi = q.sh[15];
    assign busy = q.busy;
    assign done = q.done;
    assign rx_word = q.rx;
endmodule // spsd_shift

// *** verif/spsd_props.sv ***
// spsd_props.sv: port checks of the serial status/data block.
// assumes avalon reads of status carry data at the ack edge.
`timescale 1ns/1ps
`include "spsd_defs.svh"
module spsd_props
(
    input wire logic        SYS_CLK,
    input wire logic        SRST,
    input wire logic [15:0] AVS_ADDRESS,
    input wire logic        AVS_READ,
    input wire logic        AVS_WRITE,
    input wire logic [31:0] AVS_READDATA,
    input wire logic        AVS_WAITREQUEST,
    input wire logic        IRQ
);
    logic [31:0] d;
    logic        st;
    assign d  = AVS_READDATA;
    assign st = AVS_READ & ~AVS_WAITREQUEST
              & (AVS_ADDRESS == `SPSD_OFF_STATUS);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);
    a_ack_one_cycle: assert property ($rose(AVS_READ | AVS_WRITE)
        |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
        else $error("ack not one cycle after request");
    a_tx_count_max: assert property (st |-> d[13:11] <= 3'h4)
        else $error("tx count above four");
    a_rx_count_max: assert property (st |-> d[10:8] <= 3'h4)
        else $error("rx count above four");
    a_tx_space_cnt: assert property (st |-> d[1] == (d[13:11] != 3'h4))
        else $error("tx space flag disagrees with count");
    a_rx_data_cnt: assert property (st |-> d[0] == (d[10:8] != 3'h0))
        else $error("rx data flag disagrees with count");
    a_tx_irq_lvl: assert property (st |-> d[15] == (d[13:11] < 3'h2))
        else $error("tx irq indicator wrong");
    a_rx_irq_lvl: assert property (st |-> d[14] == (d[10:8] != 3'h0))
        else $error("rx irq indicator wrong");
    a_gap_not_idle: assert property (st && d[3] |-> !d[2])
        else $error("gap and idle together");
    a_irq_reset: assert property ($fell(SRST) |-> !IRQ)
        else $error("irq high after reset");
endmodule // spsd_props
bind spsd_top spsd_props u_spsd_props (.SYS_CLK(SYS_CLK), .SRST(SRST),
    .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ),
    .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
    .AVS_WAITREQUEST(AVS_WAITREQUEST), .IRQ(IRQ));

// *** verif/spsd_link_model.sv ***
// spsd_link_model.sv: serial peripheral, one 8-bit frame per go.
// assumes mode 0, msb first; clock stands low between frames.
`timescale 1ns/1ps
module spsd_link_model
(
    input  wire logic        go,
    input  wire logic [15:0] word,
    output logic             sck,
    output logic             miso,
    input  wire logic        mosi,
    output logic [15:0]      got,
    output logic             done
);
    initial
    begin
        sck  = 1'b0;
        miso = 1'b1;
        got  = 16'h0;
        done = 1'b0;
    end
    always @(posedge go)
    begin
        done = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            miso = word[i];
            #62.5 sck = 1'b1;
            got = {got[14:0], mosi};
            #62.5 sck = 1'b0;
        end
        // released line: inverse so a stale bit cannot pass
        #62.5 miso = ~miso;
        done = 1'b1;
    end
endmodule // spsd_link_model

// *** verif/spsd_tb.sv ***
// spsd_tb.sv: self-checking bench of the serial status/data block.
// assumes spsd_link_model on the link and spsd_props bound in.
`timescale 1ns/1ps
`include "spsd_defs.svh"
module spsd_tb;
    logic        clk = 0, srst = 1, rd_s = 0, wr_s = 0, go = 0;
    logic [15:0] adr = 0, word = 0, got;
    logic [31:0] wd = 0, rdat, r;
    logic [1:0]  resp, rs;
    logic        wreq, sck, miso, mosi, irq, done;
    int          bad_count = 0, comparisons = 0;
    logic [7:0]  txw [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
    logic [7:0]  rxw [4] = '{8'h5A, 8'hC3, 8'h18, 8'hE7};
    always #2 clk = ~clk;
    spsd_top u_spsd_top (.SYS_CLK(clk), .SRST(srst), .AVS_ADDRESS(adr),
        .AVS_READ(rd_s), .AVS_WRITE(wr_s), .AVS_WRITEDATA(wd),
        .AVS_BYTEENABLE(4'hF), .AVS_READDATA(rdat),
        .AVS_WAITREQUEST(wreq), .AVS_RESPONSE(resp), .LINK_SCK(sck),
        .LINK_MISO(miso), .LINK_MOSI(mosi), .IRQ(irq));
    spsd_link_model u_spsd_link_model (.go(go), .word(word), .sck(sck),
        .miso(miso), .mosi(mosi), .got(got), .done(done));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e)
        begin
            bad_count++;
            $display("[ERR] %0t: got %h, expected %h", $time, s, e);
        end
    endtask
    task automatic bus(input logic w, input logic [15:0] a,
                       input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        adr  <= a;
        wd   <= d;
        wr_s <= w;
        rd_s <= !w;
        @(posedge clk);
        while (wreq !== 1'b0 && n < 100)
        begin
            n++;
            @(posedge clk);
        end
        if (n == 100)
            bad_count++;
        r = rdat;
        rs = resp;
        rd_s <= 1'b0;
        wr_s <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic st();
        bus(1'b0, `SPSD_OFF_STATUS, 32'h0);
    endtask
    task automatic t_reset();
        st();
        chk(r, 32'h8006);
        bus(1'b0, `SPSD_OFF_DATA, 32'h0);
        chk(r, 32'h0);
        bus(1'b0, 16'hF8FC, 32'h0);
        chk(rs, 2'b11);
    endtask
    task automatic t_fill();
        wr(`SPSD_OFF_CTRL, 32'h1);
        wr(`SPSD_OFF_SIZE, `SPSD_SIZE_8);
        wr(`SPSD_OFF_GAP, 32'hC8);
        wr(`SPSD_OFF_CTRL, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            wr(`SPSD_OFF_DATA, {24'h0, txw[i]});
            st();
            chk(r[13:11], i + 1);
            chk(r[1], i < 3);
            chk(r[15], i < 1);
        end
        chk(r[2], 1);
        wr(`SPSD_OFF_DATA, 32'hEE);
        st();
        chk(r[13:7], 7'h41);
        chk(irq, 0);
        wr(`SPSD_OFF_IRQ_MASK, 32'h1);
        repeat (3) @(posedge clk);
        chk(irq, 1);
        wr(`SPSD_OFF_STATUS, 32'h0);
        st();
        chk(r[7], 1);
        wr(`SPSD_OFF_STATUS, 32'h80);
        st();
        chk(r[7], 0);
        wr(`SPSD_OFF_IRQ_ST, 32'h1);
        repeat (3) @(posedge clk);
        chk(irq, 0);
        wr(`SPSD_OFF_DATA, 32'h11);
        wr(`SPSD_OFF_CTRL, 32'h3);
        st();
        chk(r[7], 0);
        wr(`SPSD_OFF_IRQ_ST, 32'h1);
    endtask
    task automatic t_frames();
        int n;
        wr(`SPSD_OFF_CTRL, 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            word <= {8'h0, rxw[i]};
            repeat (20) @(posedge clk);
            go <= 1'b1;
            n = 0;
            @(posedge clk);
            go <= 1'b0;
            while (done !== 1'b1 && n < 1000)
            begin
                n++;
                @(posedge clk);
            end
            if (n == 1000)
                bad_count++;
            // dropped overrun words must not reach the wire
            chk(got[7:0], txw[i]);
            repeat (10) @(posedge clk);
            st();
            chk(r[10:8], i + 1);
            chk(r[3:2], 2'b10);
            chk(r[14], 1);
            repeat (250) @(posedge clk);
        end
        st();
        chk(r[13:0], 14'h0407);
    endtask
    task automatic t_drain();
        for (int i = 0; i < 4; i++)
        begin
            bus(1'b0, `SPSD_OFF_DATA, 32'h0);
            chk(r, {24'h0, rxw[i]});
        end
        st();
        chk(r[0], 0);
    endtask
    task automatic tally_and_finish();
        $display("bad_count=%0d comparisons=%0d", bad_count, comparisons);
        if (bad_count == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_fill();
        t_frames();
        t_drain();
        tally_and_finish();
    end
    initial
    begin
        // about ten times the expected run
        #100000;
        bad_count++;
        tally_and_finish();
    end
endmodule // spsd_tb
